// ### inc/cfa_pkg.sv
// Constants and frame type for the CAN acceptance filter
// Assumes: imported by the filter top, its FIFO and the bench modules
// What this block does
// - OR all center flags into one request
// - Enabled tx or rx success sets flag
// - Only software clears a request flag
// - Request needs global and CAN enables set
// - Error and status sources individually enabled
// - Compare only frames free of bit errors
// - Lowest ready center passing all tests wins
// - Compare 11 or 29 identifier bits
// - Mask enable compares only mask-one bits
// - Center 15 mask ANDed with global mask
// - Optional masked compare of media bytes
// - Load only when every enabled test passes
// - Format selects direction and 0-8 bytes
// - Center 15 is receive only
// - Reload transmitter from lowest transmit center
// - Unread and no overwrite: discard frame
// - Overwrite enabled: replace data, flag overwrite
// - Center 15 keeps second frame hidden
// - Clearing center 15 flags loads buffer
// - Third frame discarded or replaces buffer
// - Five mask sets provided
package cfa_pkg;
   localparam int NUM_CTR    = 15;
   localparam int C15_IDX    = 14;
   localparam int ID_W       = 29;
   localparam int STD_W      = 11;
   localparam int MEDIA_W    = 16;
   localparam int DATA_W     = 64;
   localparam int LEN_W      = 4;
   localparam int MAX_BYTES  = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int CTR_W      = 4;
   localparam logic [ID_W-1:0] STD_CMP = 29'h1FFC0000;

   typedef struct packed {
      logic              ok;
      logic              ext;
      logic [ID_W-1:0]   id;
      logic [LEN_W-1:0]  len;
      logic [DATA_W-1:0] data;
   } cfa_frame_t;

   localparam int FRAME_W = $bits(cfa_frame_t);
endpackage

// ### inc/cfa_fifo_if.sv
// Ready/valid link between the filter and its frame FIFO
// Assumes: one producer view, one FIFO view
`timescale 1ns/1ps
interface cfa_fifo_if #(parameter int W = 8);
   logic         w_valid;
   logic         w_ready;
   logic [W-1:0] w_data;
   logic         r_valid;
   logic         r_ready;
   logic [W-1:0] r_data;
   modport src  (output w_valid, w_data, r_ready, input w_ready, r_valid, r_data);
   modport fifo (input w_valid, w_data, r_ready, output w_ready, r_valid, r_data);
endinterface

// ### src/cfa_fifo.sv
// Frame FIFO in front of the acceptance filter
// Assumes: DEPTH is a power of two, one clock
`timescale 1ns/1ps
module cfa_fifo
   import cfa_pkg::*;
#(
   parameter int W     = FRAME_W,
   parameter int DEPTH = FIFO_DEPTH
)(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   cfa_fifo_if.fifo  f
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0]           wp;
      logic [AW-1:0]           rp;
      logic [AW:0]             cnt;
      logic                    rdy;
   } cfa_fifo_st_t;

   cfa_fifo_st_t st_r;
   cfa_fifo_st_t st_nxt;
   logic         push;
   logic         pop;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;
      push   = f.w_valid && st_r.rdy;
      pop    = (st_r.cnt != '0) && f.r_ready;
      if (push)
      begin
         st_nxt.mem[st_r.wp] = f.w_data;
         st_nxt.wp           = AW'(st_r.wp + 1'b1);
      end
      if (pop)
      begin
         st_nxt.rp = AW'(st_r.rp + 1'b1);
      end
      st_nxt.cnt = (AW+1)'(st_r.cnt + push - pop);
      st_nxt.rdy = st_nxt.cnt != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         st_r     <= '0;
         st_r.rdy <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign f.w_ready = st_r.rdy;
   assign f.r_valid = st_r.cnt != '0;
   assign f.r_data  = st_r.mem[st_r.rp];
endmodule

// ### src/cfa_filter.sv
// Acceptance filter, message center storage and CAN request logic
// Assumes: frames from the protocol engine on MCLK_I, config from
// processor registers as plain ports, clears as one-cycle pulses
`timescale 1ns/1ps
module cfa_filter
   import cfa_pkg::*;
#(
   parameter int FDEPTH = FIFO_DEPTH
)(
   input  wire logic                            MCLK_I,
   input  wire logic                            RESETN_I,
   input  wire logic                            FRM_VALID_I,
   input  wire logic                            FRM_OK_I,
   input  wire logic                            FRM_EXT_I,
   input  wire logic [ID_W-1:0]                 FRM_ID_I,
   input  wire logic [LEN_W-1:0]                FRM_LEN_I,
   input  wire logic [DATA_W-1:0]               FRM_DATA_I,
   output logic                                 FRM_READY_O,
   input  wire logic                            FILTER_HOLD_I,
   input  wire logic [STD_W-1:0]                STD_MASK_I,
   input  wire logic [ID_W-1:0]                 EXT_MASK_I,
   input  wire logic [MEDIA_W-1:0]              MEDIA_MASK_I,
   input  wire logic [MEDIA_W-1:0]              MEDIA_ARB_I,
   input  wire logic [STD_W-1:0]                C15_STD_MASK_I,
   input  wire logic [ID_W-1:0]                 C15_EXT_MASK_I,
   input  wire logic [NUM_CTR-1:0]              CENTER_READY_I,
   input  wire logic [NUM_CTR-1:0]              CENTER_TX_I,
   input  wire logic [NUM_CTR-1:0]              EXTENDED_FORMAT_SELECT_I,
   input  wire logic [NUM_CTR-1:0]              ID_MASK_ENABLE_I,
   input  wire logic [NUM_CTR-1:0]              MEDIA_MATCH_ENABLE_I,
   input  wire logic [NUM_CTR-1:0]              OVERWRITE_ENABLE_I,
   input  wire logic [NUM_CTR-1:0]              TX_IRQ_ENABLE_I,
   input  wire logic [NUM_CTR-1:0]              RX_IRQ_ENABLE_I,
   input  wire logic [NUM_CTR-1:0][ID_W-1:0]    CENTER_ARB_I,
   input  wire logic [NUM_CTR-1:0][LEN_W-1:0]   CENTER_LEN_I,
   input  wire logic [NUM_CTR-1:0]              CLR_REQUEST_I,
   input  wire logic [NUM_CTR-1:0]              CLR_DATA_UPDATED_I,
   input  wire logic [NUM_CTR-1:0]              CLR_OVERWRITE_I,
   input  wire logic                            CLR_EXTRA_REQUEST_I,
   input  wire logic                            TX_DONE_I,
   input  wire logic [CTR_W-1:0]                TX_DONE_CTR_I,
   input  wire logic                            TX_RELOAD_I,
   input  wire logic                            ERR_EVENT_I,
   input  wire logic                            STAT_EVENT_I,
   input  wire logic                            ERROR_IRQ_ENABLE_I,
   input  wire logic                            STATUS_IRQ_ENABLE_I,
   input  wire logic                            GLOBAL_IRQ_ENABLE_I,
   input  wire logic                            CAN_IRQ_ENABLE_I,
   output logic                                 CAN_IRQ_O,
   output logic                                 ACCEPT_VALID_O,
   output logic [CTR_W-1:0]                     ACCEPT_CTR_O,
   output logic [NUM_CTR-1:0]                   CENTER_REQUEST_FLAG_O,
   output logic [NUM_CTR-1:0]                   DATA_UPDATED_FLAG_O,
   output logic [NUM_CTR-1:0]                   RX_OVERWRITE_FLAG_O,
   output logic                                 EXTRA_REQUEST_FLAG_O,
   output logic [NUM_CTR-1:0][DATA_W-1:0]       CENTER_DATA_O,
   output logic                                 TX_SEL_VALID_O,
   output logic [CTR_W-1:0]                     TX_SEL_CTR_O
);
   typedef struct packed {
      logic [NUM_CTR-1:0][DATA_W-1:0] data;
      logic [DATA_W-1:0]              buf_data;
      logic                           buf_v;
      logic [NUM_CTR-1:0]             req;
      logic [NUM_CTR-1:0]             data_updated_flag;
      logic [NUM_CTR-1:0]             row;
      logic                           extra_request_flag;
      logic                           irq;
      logic                           acc_v;
      logic [CTR_W-1:0]               acc_ctr;
      logic                           tx_v;
      logic [CTR_W-1:0]               tx_ctr;
   } cfa_state_t;

   cfa_state_t         st_r;
   cfa_state_t         st_nxt;
   cfa_frame_t         hd;
   cfa_frame_t         in_frm;
   logic [NUM_CTR-1:0] hit;
   logic [CTR_W-1:0]   win;
   logic               found;
   logic               pop;
   logic               c15_move;

   // ==========================================================
   // Frame FIFO
   cfa_fifo_if #(.W(FRAME_W)) ff ();

   assign in_frm.ok   = FRM_OK_I;
   assign in_frm.ext  = FRM_EXT_I;
   assign in_frm.id   = FRM_ID_I;
   assign in_frm.len  = FRM_LEN_I;
   assign in_frm.data = FRM_DATA_I;
   assign ff.w_valid  = FRM_VALID_I;
   assign ff.w_data   = in_frm;
   assign ff.r_ready  = !FILTER_HOLD_I;
   assign hd          = cfa_frame_t'(ff.r_data);
   assign pop         = ff.r_valid && ff.r_ready;

   cfa_fifo #(
      .W     (FRAME_W),
      .DEPTH (FDEPTH)
   ) u_fifo (
      .clk_i   (MCLK_I),
      .rst_n_i (RESETN_I),
      .f       (ff.fifo)
   );

   // ==========================================================
   // Per-center identifier and media tests
   for (genvar i = 0; i < NUM_CTR; i++)
   begin : g_ctr
      logic [ID_W-1:0] cmp;
      logic [ID_W-1:0] gm;
      logic [ID_W-1:0] msk;
      logic            id_ok;
      logic            md_ok;
      logic            rx_mode;
      assign cmp = EXTENDED_FORMAT_SELECT_I[i] ? {ID_W{1'b1}} : STD_CMP;
      assign gm  = EXTENDED_FORMAT_SELECT_I[i] ? EXT_MASK_I
                                               : {STD_MASK_I, {(ID_W-STD_W){1'b0}}};
      if (i == C15_IDX)
      begin : g_c15
         assign msk = gm & (EXTENDED_FORMAT_SELECT_I[i] ? C15_EXT_MASK_I
                          : {C15_STD_MASK_I, {(ID_W-STD_W){1'b0}}});
         assign rx_mode = 1'b1;
      end
      else
      begin : g_std
         assign msk = gm;
         assign rx_mode = !CENTER_TX_I[i];
      end
      assign id_ok = (hd.ext == EXTENDED_FORMAT_SELECT_I[i]) &&
                     (((hd.id ^ CENTER_ARB_I[i]) & cmp &
                       (ID_MASK_ENABLE_I[i] ? msk : {ID_W{1'b1}})) == '0);
      assign md_ok = !MEDIA_MATCH_ENABLE_I[i] ||
                     (((hd.data[MEDIA_W-1:0] ^ MEDIA_ARB_I) & MEDIA_MASK_I) == '0);
      assign hit[i] = hd.ok && CENTER_READY_I[i] && rx_mode && id_ok && md_ok;
   end

   // Lowest numbered hit wins
   always_comb
   begin
      win   = '0;
      found = 1'b0;
      for (int k = NUM_CTR - 1; k >= 0; k--)
      begin
         if (hit[k])
         begin
            win   = CTR_W'(k);
            found = 1'b1;
         end
      end
   end

   // Keep only the configured number of data bytes
   function automatic logic [DATA_W-1:0] keep_len(logic [DATA_W-1:0] d,
                                                 logic [LEN_W-1:0]  n);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int b = 0; b < MAX_BYTES; b++)
      begin
         if (b < int'(n))
         begin
            m[b*8 +: 8] = 8'hFF;
         end
      end
      return d & m;
   endfunction

   assign c15_move = st_r.buf_v && !st_r.data_updated_flag[C15_IDX] && !st_r.req[C15_IDX] &&
                     !st_r.extra_request_flag;

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;
      // Software clears; hardware sets below win
      st_nxt.req   = st_r.req & ~CLR_REQUEST_I;
      st_nxt.data_updated_flag  = st_r.data_updated_flag & ~CLR_DATA_UPDATED_I;
      st_nxt.row   = st_r.row & ~CLR_OVERWRITE_I;
      st_nxt.extra_request_flag = st_r.extra_request_flag & ~CLR_EXTRA_REQUEST_I;
      // Hidden buffer to visible center 15
      if (c15_move)
      begin
         st_nxt.data[C15_IDX] = st_r.buf_data;
         st_nxt.data_updated_flag[C15_IDX] = 1'b1;
         st_nxt.req[C15_IDX]  = st_nxt.req[C15_IDX] | RX_IRQ_ENABLE_I[C15_IDX];
         st_nxt.buf_v         = 1'b0;
      end
      // Transmit completion
      if (TX_DONE_I && TX_DONE_CTR_I != '0 && TX_DONE_CTR_I <= CTR_W'(C15_IDX))
      begin
         if (TX_IRQ_ENABLE_I[TX_DONE_CTR_I - 1'b1])
         begin
            st_nxt.req[TX_DONE_CTR_I - 1'b1] = 1'b1;
         end
      end
      // Received frame disposition
      st_nxt.acc_v   = pop && found;
      st_nxt.acc_ctr = CTR_W'(win + 1'b1);
      if (pop && found)
      begin
         if (win == CTR_W'(C15_IDX))
         begin
            if (!st_nxt.data_updated_flag[C15_IDX] && !st_nxt.buf_v)
            begin
               st_nxt.data[C15_IDX] = keep_len(hd.data, CENTER_LEN_I[C15_IDX]);
               st_nxt.data_updated_flag[C15_IDX] = 1'b1;
               st_nxt.req[C15_IDX]  = st_nxt.req[C15_IDX] | RX_IRQ_ENABLE_I[C15_IDX];
            end
            else if (!st_nxt.buf_v)
            begin
               st_nxt.buf_data = keep_len(hd.data, CENTER_LEN_I[C15_IDX]);
               st_nxt.buf_v    = 1'b1;
               st_nxt.extra_request_flag    = 1'b1;
            end
            else if (OVERWRITE_ENABLE_I[C15_IDX])
            begin
               st_nxt.buf_data = keep_len(hd.data, CENTER_LEN_I[C15_IDX]);
               st_nxt.extra_request_flag    = 1'b1;
            end
         end
         else if (!st_nxt.data_updated_flag[win] || OVERWRITE_ENABLE_I[win])
         begin
            st_nxt.data[win] = keep_len(hd.data, CENTER_LEN_I[win]);
            st_nxt.row[win]  = st_nxt.row[win] | st_nxt.data_updated_flag[win];
            st_nxt.data_updated_flag[win] = 1'b1;
            st_nxt.req[win]  = st_nxt.req[win] | RX_IRQ_ENABLE_I[win];
         end
      end
      // Transmitter reload after lost arbitration or error
      if (TX_RELOAD_I)
      begin
         st_nxt.tx_v = 1'b0;
         for (int k = C15_IDX - 1; k >= 0; k--)
         begin
            if (CENTER_READY_I[k] && CENTER_TX_I[k])
            begin
               st_nxt.tx_v   = 1'b1;
               st_nxt.tx_ctr = CTR_W'(k + 1);
            end
         end
      end
      // Single CAN request
      st_nxt.irq = GLOBAL_IRQ_ENABLE_I && CAN_IRQ_ENABLE_I &&
                   ((|st_r.req) ||
                    (ERR_EVENT_I && ERROR_IRQ_ENABLE_I) ||
                    (STAT_EVENT_I && STATUS_IRQ_ENABLE_I));
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // Outputs
   assign FRM_READY_O           = ff.w_ready;
   assign CAN_IRQ_O             = st_r.irq;
   assign ACCEPT_VALID_O        = st_r.acc_v;
   assign ACCEPT_CTR_O          = st_r.acc_ctr;
   assign CENTER_REQUEST_FLAG_O = st_r.req;
   assign DATA_UPDATED_FLAG_O   = st_r.data_updated_flag;
   assign RX_OVERWRITE_FLAG_O   = st_r.row;
   assign EXTRA_REQUEST_FLAG_O  = st_r.extra_request_flag;
   assign CENTER_DATA_O         = st_r.data;
   assign TX_SEL_VALID_O        = st_r.tx_v;
   assign TX_SEL_CTR_O          = st_r.tx_ctr;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge MCLK_I);
   endclocking
   default disable iff (!RESETN_I);

   sequence c15_waiting;
      c15_move;
   endsequence

   sequence c15_loaded;
      DATA_UPDATED_FLAG_O[C15_IDX] && CENTER_DATA_O[C15_IDX] == $past(st_r.buf_data);
   endsequence

   irq_or_a: assert property ((|CENTER_REQUEST_FLAG_O) && GLOBAL_IRQ_ENABLE_I &&
      CAN_IRQ_ENABLE_I |=> CAN_IRQ_O)
      else $error("Pending center flag gave no request");

   irq_gate_a: assert property (CAN_IRQ_O |->
      $past(GLOBAL_IRQ_ENABLE_I && CAN_IRQ_ENABLE_I))
      else $error("Request without both enables");

   src_gate_a: assert property (!(|CENTER_REQUEST_FLAG_O) &&
      !(ERR_EVENT_I && ERROR_IRQ_ENABLE_I) &&
      !(STAT_EVENT_I && STATUS_IRQ_ENABLE_I) |=> !CAN_IRQ_O)
      else $error("Request from a gated source");

   req_hold_a: assert property ((st_r.req & ~st_nxt.req & ~CLR_REQUEST_I) == '0)
      else $error("Request flag cleared by hardware");

   rx_set_a: assert property (pop && found && win != CTR_W'(C15_IDX) && !st_r.data_updated_flag[win] &&
      RX_IRQ_ENABLE_I[win] |=> CENTER_REQUEST_FLAG_O[$past(win)])
      else $error("Reception did not set request flag");

   bit_err_a: assert property (pop && !hd.ok |=> !ACCEPT_VALID_O)
      else $error("Errored frame accepted");

   first_win_a: assert property (ACCEPT_VALID_O |->
      ($past(hit) & ~({NUM_CTR{1'b1}} << (ACCEPT_CTR_O - 1'b1))) == '0)
      else $error("Lower center skipped");

   keep_old_a: assert property (pop && found && win != CTR_W'(C15_IDX) && st_r.data_updated_flag[win] &&
      !CLR_DATA_UPDATED_I[win] && !OVERWRITE_ENABLE_I[win] |=>
      CENTER_DATA_O[$past(win)] == $past(CENTER_DATA_O[win]))
      else $error("Unread data changed");

   ovwr_flag_a: assert property (pop && found && win != CTR_W'(C15_IDX) && st_r.data_updated_flag[win] &&
      !CLR_DATA_UPDATED_I[win] && OVERWRITE_ENABLE_I[win] |=>
      RX_OVERWRITE_FLAG_O[$past(win)])
      else $error("Overwrite flag not set");

   c15_move_a: assert property (c15_waiting |=> c15_loaded)
      else $error("Buffered frame not moved");

   c15_third_a: assert property (pop && found && win == CTR_W'(C15_IDX) &&
      st_r.data_updated_flag[C15_IDX] && st_r.buf_v |=> $stable(CENTER_DATA_O[C15_IDX]))
      else $error("Visible center 15 disturbed");

   tx_pick_a: assert property (TX_RELOAD_I |=> TX_SEL_VALID_O ==
      $past(|(CENTER_READY_I[C15_IDX-1:0] & CENTER_TX_I[C15_IDX-1:0])))
      else $error("Transmit reload selection wrong");
endmodule

// ### bench/cfa_frame_src.sv
// Frame source standing in for the protocol engine and far nodes
// Assumes: one clock, frames queued by the bench through push
`timescale 1ns/1ps
module cfa_frame_src
   import cfa_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ready_i,
   output logic      valid_o,
   output cfa_frame_t frm_o
);
   cfa_frame_t q[$];

   // ==========================================================
   // Queue filled by the bench
   task automatic push(input cfa_frame_t f);
      q.push_back(f);
   endtask

   // ==========================================================
   // Offer held until taken, idle lines toggle every cycle
   always @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         valid_o <= 1'b0;
         frm_o   <= '0;
      end
      else
      begin
         if (valid_o && ready_i)
            void'(q.pop_front());
         valid_o <= (q.size() != 0);
         frm_o   <= (q.size() != 0) ? q[0] : ~frm_o;
      end
   end
endmodule

// ### bench/can_acceptance_filter_irq_tb_top.sv
// Self-checking bench for the acceptance filter and request logic
// Assumes: cfa_filter and the frame source model on one clock
`timescale 1ns/1ps
module can_acceptance_filter_irq_tb_top
   import cfa_pkg::*;
();
   localparam logic [ID_W-1:0] id_a = 29'h048C0000;
   localparam logic [ID_W-1:0] id_c = 29'h0AA80000;
   localparam logic [ID_W-1:0] id_d = 29'h13300000;
   localparam logic [ID_W-1:0] id_e = 29'h0ABCDEF1;
   localparam logic [NUM_CTR-1:0] tx_rdy [3] = '{15'h407E, 15'h407A, 15'h4000};
   localparam logic [CTR_W-1:0]   tx_exp [3] = '{4'h3, 4'h7, 4'h0};

   logic clk = 1'b0, rst_n = 1'b0, hold = 1'b0, tx_done = 1'b0, tx_reload = 1'b0;
   logic gie = 1'b1, cie = 1'b1, clr_xr = 1'b0;
   logic [1:0]          ev = '0, ev_en = '0;
   logic [CTR_W-1:0]    done_ctr = '0;
   logic [STD_W-1:0]    std_mask = 11'h7F0, c15_std = 11'h0FF;
   logic [ID_W-1:0]     ext_mask = '1, c15_ext = '1;
   logic [MEDIA_W-1:0]  med_mask = 16'hFF00, med_arb = 16'hA5C3;
   logic [NUM_CTR-1:0]  rdy = 15'h403E, ctx = 15'h4000, exf = 15'h0008, mme = 15'h4010;
   logic [NUM_CTR-1:0]  mde = 15'h0020, owe = '0, tie = '0, rie = '1;
   logic [NUM_CTR-1:0]  clr_rq = '0, clr_du = '0, clr_ow = '0, rq_o, du_o, ow_o;
   logic [NUM_CTR-1:0][ID_W-1:0]   arb;
   logic [NUM_CTR-1:0][LEN_W-1:0]  clen;
   logic [NUM_CTR-1:0][DATA_W-1:0] cdata;
   logic                ready, irq, acc_v, xrq, tx_v, s_valid;
   logic [CTR_W-1:0]    acc_ctr, tx_ctr, last_ctr = '0;
   cfa_frame_t          s_frm;
   int                  n_mismatch = 0, comparisons = 0, n_acc = 0, base;

   cfa_frame_src cfa_frame_src_i (.clk_i(clk), .rst_n_i(rst_n), .ready_i(ready),
      .valid_o(s_valid), .frm_o(s_frm));

   cfa_filter #(.FDEPTH(FIFO_DEPTH)) cfa_filter_i (
      .MCLK_I(clk), .RESETN_I(rst_n), .FRM_VALID_I(s_valid), .FRM_OK_I(s_frm.ok),
      .FRM_EXT_I(s_frm.ext), .FRM_ID_I(s_frm.id), .FRM_LEN_I(s_frm.len),
      .FRM_DATA_I(s_frm.data), .FRM_READY_O(ready), .FILTER_HOLD_I(hold),
      .STD_MASK_I(std_mask), .EXT_MASK_I(ext_mask), .MEDIA_MASK_I(med_mask),
      .MEDIA_ARB_I(med_arb), .C15_STD_MASK_I(c15_std), .C15_EXT_MASK_I(c15_ext),
      .CENTER_READY_I(rdy), .CENTER_TX_I(ctx), .EXTENDED_FORMAT_SELECT_I(exf),
      .ID_MASK_ENABLE_I(mme), .MEDIA_MATCH_ENABLE_I(mde), .OVERWRITE_ENABLE_I(owe),
      .TX_IRQ_ENABLE_I(tie), .RX_IRQ_ENABLE_I(rie), .CENTER_ARB_I(arb),
      .CENTER_LEN_I(clen), .CLR_REQUEST_I(clr_rq), .CLR_DATA_UPDATED_I(clr_du),
      .CLR_OVERWRITE_I(clr_ow), .CLR_EXTRA_REQUEST_I(clr_xr), .TX_DONE_I(tx_done),
      .TX_DONE_CTR_I(done_ctr), .TX_RELOAD_I(tx_reload), .ERR_EVENT_I(ev[0]),
      .STAT_EVENT_I(ev[1]), .ERROR_IRQ_ENABLE_I(ev_en[0]),
      .STATUS_IRQ_ENABLE_I(ev_en[1]), .GLOBAL_IRQ_ENABLE_I(gie),
      .CAN_IRQ_ENABLE_I(cie), .CAN_IRQ_O(irq), .ACCEPT_VALID_O(acc_v),
      .ACCEPT_CTR_O(acc_ctr), .CENTER_REQUEST_FLAG_O(rq_o),
      .DATA_UPDATED_FLAG_O(du_o), .RX_OVERWRITE_FLAG_O(ow_o),
      .EXTRA_REQUEST_FLAG_O(xrq), .CENTER_DATA_O(cdata), .TX_SEL_VALID_O(tx_v),
      .TX_SEL_CTR_O(tx_ctr));

   always #25 clk = ~clk;

   // ==========================================================
   // Accept pulse monitor
   always @(posedge clk)
      if (acc_v === 1'b1)
      begin
         n_acc    <= n_acc + 1;
         last_ctr <= acc_ctr;
      end

   // ==========================================================
   // Shared tasks
   task automatic close_out;
      if (n_mismatch == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic frm(input logic e, input logic ok, input logic [ID_W-1:0] id,
                      input logic [DATA_W-1:0] d, input logic [CTR_W-1:0] exp);
      int b;
      b = n_acc;
      cfa_frame_src_i.push('{ok, e, id, 4'h8, d});
      for (int i = 0; i < 40 && cfa_frame_src_i.q.size() != 0; i++)
         @(posedge clk);
      tick(4);
      chk(n_acc - b, exp != 0);
      if (exp != 0)
         chk(last_ctr, exp);
   endtask

   task automatic clear(input logic [NUM_CTR-1:0] m);
      clr_du <= m;
      clr_rq <= m;
      clr_ow <= m;
      clr_xr <= m[14];
      tick(1);
      clr_du <= '0;
      clr_rq <= '0;
      clr_ow <= '0;
      clr_xr <= 1'b0;
      tick(3);
   endtask

   // ==========================================================
   // Watchdog
   initial
   begin
      tick(6000);
      n_mismatch++;
      close_out();
   end

   // ==========================================================
   // Test sequence
   initial
   begin
      arb <= {29'h0F0C0000, {8{29'h0}}, id_c, 29'h05540000, id_e, id_a, id_a, 29'h0};
      clen <= {{13{4'h8}}, 4'h3, 4'h8};
      tick(20);
      rst_n <= 1'b1;
      tick(2);
      chk(ready, 1'b1);
      chk(irq, 1'b0);
      frm(0, 1, id_a, 64'h1122334455667788, 4'h2);
      chk(cdata[1], 64'h667788);
      chk(cdata[2], 64'h0);
      chk(rq_o, 15'h0002);
      chk(irq, 1'b1);
      frm(0, 1, id_a | 29'h1, 64'hFFFFFFFF, 4'h2);
      chk(cdata[1], 64'h667788);
      chk(ow_o, 15'h0);
      owe <= 15'h0002;
      frm(0, 1, id_a, 64'hAABBCCDD, 4'h2);
      chk(cdata[1], 64'hBBCCDD);
      chk(ow_o, 15'h0002);
      frm(1, 1, id_e ^ 29'h1, 64'h1, 4'h0);
      frm(1, 0, id_e, 64'h2, 4'h0);
      frm(1, 1, id_e, 64'h3, 4'h4);
      frm(0, 1, 29'h05140000, 64'h4, 4'h0);
      frm(0, 1, 29'h05780000, 64'h5, 4'h5);
      frm(0, 1, id_c, 64'h5AC3, 4'h0);
      frm(0, 1, id_c, 64'hA5FF, 4'h6);
      frm(0, 1, id_d, 64'hD1, 4'hF);
      frm(0, 1, id_d, 64'hD2, 4'hF);
      chk(xrq, 1'b1);
      frm(0, 1, id_d, 64'hD3, 4'hF);
      chk(cdata[14], 64'hD1);
      clear(15'h4000);
      chk(cdata[14], 64'hD2);
      chk(du_o[14], 1'b1);
      frm(0, 1, id_d, 64'hD4, 4'hF);
      owe <= 15'h4002;
      frm(0, 1, id_d, 64'hD5, 4'hF);
      chk(cdata[14], 64'hD2);
      clear(15'h4000);
      chk(cdata[14], 64'hD5);
      chk(rq_o[1], 1'b1);
      mme <= 15'h4018;
      ext_mask <= 29'h1FFFFFFE;
      owe <= 15'h400A;
      frm(1, 1, id_e ^ 29'h1, 64'h7, 4'h4);
      chk(cdata[3], 64'h7);
      chk(ow_o[3], 1'b1);
      gie <= 1'b0;
      tick(3);
      chk(irq, 1'b0);
      gie <= 1'b1;
      cie <= 1'b0;
      tick(3);
      chk(irq, 1'b0);
      cie <= 1'b1;
      clear('1);
      chk(rq_o, 15'h0);
      chk(irq, 1'b0);
      for (int s = 0; s < 2; s++)
      begin
         ev[s] <= 1'b1;
         tick(3);
         chk(irq, 1'b0);
         ev_en[s] <= 1'b1;
         tick(3);
         chk(irq, 1'b1);
         ev[s] <= 1'b0;
         ev_en[s] <= 1'b0;
         tick(3);
      end
      ctx <= 15'h4044;
      for (int k = 0; k < 3; k++)
      begin
         rdy <= tx_rdy[k];
         tick(1);
         tx_reload <= 1'b1;
         tick(1);
         tx_reload <= 1'b0;
         tick(2);
         chk(tx_v, tx_exp[k] != 0);
         if (tx_exp[k] != 0)
            chk(tx_ctr, tx_exp[k]);
      end
      tie <= 15'h0040;
      for (int k = 0; k < 2; k++)
      begin
         done_ctr <= (k == 0) ? 4'h7 : 4'h3;
         tx_done <= 1'b1;
         tick(1);
         tx_done <= 1'b0;
         tick(2);
      end
      chk(rq_o, 15'h0040);
      // Buffer fills while stalled, then drains
      rdy <= 15'h403E;
      hold <= 1'b1;
      tick(1);
      for (int k = 0; k < 9; k++)
         cfa_frame_src_i.push('{1'b1, 1'b1, id_e, 4'h8, 64'(k)});
      tick(15);
      chk(ready, 1'b0);
      chk(cfa_frame_src_i.q.size(), 1);
      base = n_acc;
      hold <= 1'b0;
      tick(30);
      chk(n_acc - base, 9);
      chk(ready, 1'b1);
      close_out();
   end
endmodule
